// ---- fec_interleave_codec.sv ----
/*
  Error-correcting codec: convolutional encoder with 4x4 interleaver on
  transmit, de-interleaver and hard-decision Viterbi decoder on receive,
  each output behind a two-entry buffer.
  Assumes the packet handler feeds only data field and CRC bytes, on MCLK.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fec_defines.svh"

module fec_pair_buf #(
  parameter int WIDTH = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_reg [2];
  logic wr_reg, wr_next, rd_reg, rd_next;
  logic [1:0] cnt_reg, cnt_next;
  logic wr_en, rd_en;

  always_comb begin
    in_ready = cnt_reg != 2'h2;
    out_valid = cnt_reg != 2'h0;
    out_data = mem_reg[rd_reg];
    wr_en = in_valid && in_ready;
    rd_en = out_valid && out_ready;
    wr_next = wr_reg ^ wr_en;
    rd_next = rd_reg ^ rd_en;
    cnt_next = cnt_reg + {1'b0, wr_en} - {1'b0, rd_en};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
    if (wr_en) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule

module fec_interleave_codec #(
  parameter int LEN_W = 8
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CODING_ENABLE,
  input wire logic [1:0] LENGTH_MODE,
  input wire logic [LEN_W-1:0] PACKET_LENGTH,
  input wire logic TX_IN_VALID,
  output logic TX_IN_READY,
  input wire logic [7:0] TX_IN_DATA,
  input wire logic TX_IN_LAST,
  output logic TX_OUT_VALID,
  input wire logic TX_OUT_READY,
  output logic [7:0] TX_OUT_DATA,
  output logic TX_OUT_LAST,
  input wire logic RX_IN_VALID,
  output logic RX_IN_READY,
  input wire logic [7:0] RX_IN_DATA,
  input wire logic RX_IN_LAST,
  output logic RX_OUT_VALID,
  input wire logic RX_OUT_READY,
  output logic [7:0] RX_OUT_DATA,
  output logic RX_OUT_LAST
);
  if (LEN_W < 2 || LEN_W > 16) begin : g_len_check
    $error("LEN_W must lie between 2 and 16");
  end

  // Row write then column read of a 4x4 matrix; the map is its own inverse
  function automatic logic [15:0] transpose(input logic [15:0] x);
    logic [15:0] y;
    y = 16'h0000;
    for (int k = 0; k < 16; k++) begin
      y[15-k] = x[15-(4*(k%4)+k/4)]; // see R06
    end
    return y;
  endfunction

  function automatic logic [18:0] encode(input logic [7:0] d,
                                         input logic [2:0] s);
    logic [15:0] c;
    logic [3:0] w;
    logic [2:0] st;
    st = s;
    c = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      w = {d[7-i], st};
      c[15-2*i] = ^(w & `FEC_G0); // see R04 see R14
      c[14-2*i] = ^(w & `FEC_G1);
      st = {d[7-i], st[2:1]};
    end
    return {transpose(c), st}; // see R07
  endfunction

  function automatic fec_pkg::metric_t branch(input logic u,
      input logic [2:0] s, input logic [1:0] r);
    logic [3:0] w;
    w = {u, s};
    return {7'h00, (^(w & `FEC_G0)) ^ r[1]}
         + {7'h00, (^(w & `FEC_G1)) ^ r[0]};
  endfunction

  logic coded;
  assign coded = CODING_ENABLE // see R01 see R05
    && LENGTH_MODE == `FEC_LEN_FIXED; // see R02

  // Transmit path
  logic [15:0] pend_reg, pend_next;
  logic [1:0] pcnt_reg, pcnt_next, pad_reg, pad_next;
  logic [2:0] enc_reg, enc_next;
  logic par_reg, par_next, end_reg, end_next;
  logic txb_ready, tx_push, txb_last;

  always_comb begin
    pend_next = pend_reg;
    pcnt_next = pcnt_reg;
    pad_next = pad_reg;
    enc_next = enc_reg;
    par_next = par_reg;
    end_next = end_reg;
    tx_push = pcnt_reg != 2'h0;
    txb_last = end_reg && pcnt_reg == 2'h1;
    TX_IN_READY = pcnt_reg == 2'h0 && pad_reg == 2'h0;
    if (tx_push) begin
      if (txb_ready) begin
        pend_next = {pend_reg[7:0], 8'h00};
        pcnt_next = pcnt_reg - 2'h1;
        if (txb_last) begin
          end_next = 1'b0;
        end
      end
    end else if (pad_reg != 2'h0) begin
      {pend_next, enc_next} = encode(8'h00, enc_reg); // see R10
      pcnt_next = 2'h2;
      pad_next = pad_reg - 2'h1;
      if (pad_reg == 2'h1) begin
        end_next = 1'b1;
        enc_next = 3'h0; // see R14
      end
    end else if (TX_IN_VALID) begin
      if (coded) begin
        {pend_next, enc_next} = encode(TX_IN_DATA, enc_reg); // see R03 R04
        pcnt_next = 2'h2;
        par_next = ~par_reg;
        if (TX_IN_LAST) begin
          pad_next = par_reg ? `FEC_PAD_EVEN : `FEC_PAD_ODD; // see R11
          par_next = 1'b0;
        end
      end else begin
        pend_next = {TX_IN_DATA, 8'h00}; // see R01
        pcnt_next = 2'h1;
        end_next = TX_IN_LAST;
        enc_next = 3'h0;
        par_next = 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      pend_reg <= 16'h0000;
      pcnt_reg <= 2'h0;
      pad_reg <= 2'h0;
      enc_reg <= 3'h0;
      par_reg <= 1'b0;
      end_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      pcnt_reg <= pcnt_next;
      pad_reg <= pad_next;
      enc_reg <= enc_next;
      par_reg <= par_next;
      end_reg <= end_next;
    end
  end

  fec_pair_buf #(.WIDTH(9)) u_tx_buf (
    .clk(MCLK),
    .rst(RST),
    .in_valid(tx_push),
    .in_ready(txb_ready),
    .in_data({txb_last, pend_reg[15:8]}),
    .out_valid(TX_OUT_VALID),
    .out_ready(TX_OUT_READY),
    .out_data({TX_OUT_LAST, TX_OUT_DATA})
  );

  // Receive path: add-compare-select over the 8 trellis states
  fec_pkg::rx_state_e rs_reg, rs_next;
  fec_pkg::metric_t pm_reg [8], pm_next [8], pm_acs [8];
  fec_pkg::surv_t sv_reg [8], sv_next [8], sv_acs [8];
  fec_pkg::metric_t mn, m0, m1;
  logic [2:0] nsv, p0, p1, best;
  logic [15:0] sym_reg, sym_next;
  logic [7:0] pair_reg, pair_next, asm_reg, asm_next, rxb_data;
  logic half_reg, half_next, last_reg, last_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [4:0] steps_reg, steps_next;
  logic [2:0] acnt_reg, acnt_next;
  logic [LEN_W-1:0] nb_reg, nb_next;
  logic rxb_ready, rxb_push, rxb_last, emit, ebit;

  always_comb begin
    mn = pm_reg[0];
    for (int s = 1; s < 8; s++) begin
      if (pm_reg[s] < mn) begin
        mn = pm_reg[s];
      end
    end
    nsv = 3'h0;
    p0 = 3'h0;
    p1 = 3'h0;
    m0 = 8'h00;
    m1 = 8'h00;
    for (int ns = 0; ns < 8; ns++) begin
      nsv = 3'(ns);
      p0 = {nsv[1:0], 1'b0};
      p1 = {nsv[1:0], 1'b1};
      m0 = pm_reg[p0] - mn + branch(nsv[2], p0, sym_reg[15:14]);
      m1 = pm_reg[p1] - mn + branch(nsv[2], p1, sym_reg[15:14]);
      if (m1 < m0) begin
        pm_acs[ns] = m1; // see R09
        sv_acs[ns] = {sv_reg[p1][14:0], nsv[2]};
      end else begin
        pm_acs[ns] = m0;
        sv_acs[ns] = {sv_reg[p0][14:0], nsv[2]};
      end
    end
    best = 3'h0;
    for (int s = 1; s < 8; s++) begin
      if (pm_acs[s] < pm_acs[best]) begin
        best = 3'(s);
      end
    end
  end

  always_comb begin
    rs_next = rs_reg;
    pm_next = pm_reg;
    sv_next = sv_reg;
    sym_next = sym_reg;
    pair_next = pair_reg;
    half_next = half_reg;
    last_next = last_reg;
    cnt_next = cnt_reg;
    steps_next = steps_reg;
    asm_next = asm_reg;
    acnt_next = acnt_reg;
    nb_next = nb_reg;
    RX_IN_READY = 1'b0;
    rxb_push = 1'b0;
    rxb_data = RX_IN_DATA;
    rxb_last = RX_IN_LAST;
    emit = 1'b0;
    ebit = 1'b0;
    unique case (rs_reg)
      fec_pkg::RX_COLLECT: begin
        if (!coded) begin
          RX_IN_READY = rxb_ready;
          rxb_push = RX_IN_VALID;
        end else begin
          RX_IN_READY = 1'b1;
          if (RX_IN_VALID && !half_reg) begin
            pair_next = RX_IN_DATA;
            half_next = 1'b1;
          end else if (RX_IN_VALID) begin
            sym_next = transpose({pair_reg, RX_IN_DATA}); // see R08
            half_next = 1'b0;
            last_next = RX_IN_LAST;
            cnt_next = 4'h0;
            rs_next = fec_pkg::RX_DECODE;
          end
        end
      end
      fec_pkg::RX_DECODE: begin
        if (rxb_ready) begin
          pm_next = pm_acs;
          sv_next = sv_acs;
          sym_next = {sym_reg[13:0], 2'b00};
          if (steps_reg != `FEC_STEPS_SAT) begin
            steps_next = steps_reg + 5'h01;
          end
          emit = steps_reg >= `FEC_DELAY_MIN;
          ebit = sv_acs[best][15];
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == `FEC_GROUP_LAST) begin
            cnt_next = 4'h0;
            rs_next = last_reg ? fec_pkg::RX_FLUSH : fec_pkg::RX_COLLECT;
          end
        end
      end
      fec_pkg::RX_FLUSH: begin
        if (rxb_ready) begin
          emit = 1'b1;
          ebit = sv_reg[0][14]; // Terminated trellis ends in state zero
          sv_next[0] = {sv_reg[0][14:0], 1'b0};
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == `FEC_FLUSH_LAST) begin
            rs_next = fec_pkg::RX_COLLECT;
            for (int s = 0; s < 8; s++) begin
              pm_next[s] = (s == 0) ? 8'h00 : `FEC_METRIC_INIT;
              sv_next[s] = 16'h0000;
            end
            steps_next = 5'h00;
            cnt_next = 4'h0;
            last_next = 1'b0;
          end
        end
      end
      default: begin
        rs_next = fec_pkg::RX_COLLECT;
      end
    endcase
    if (emit) begin
      asm_next = {asm_reg[6:0], ebit};
      acnt_next = acnt_reg + 3'h1;
      if (acnt_reg == 3'h7 && nb_reg < PACKET_LENGTH) begin
        rxb_push = 1'b1; // see R12
        rxb_data = {asm_reg[6:0], ebit};
        rxb_last = nb_reg == PACKET_LENGTH - LEN_W'(1);
        nb_next = nb_reg + LEN_W'(1);
      end
    end
    if (rs_reg == fec_pkg::RX_FLUSH && rs_next == fec_pkg::RX_COLLECT) begin
      nb_next = '0;
      acnt_next = 3'h0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      rs_reg <= fec_pkg::RX_COLLECT;
      for (int s = 0; s < 8; s++) begin
        pm_reg[s] <= (s == 0) ? 8'h00 : `FEC_METRIC_INIT;
        sv_reg[s] <= 16'h0000;
      end
      sym_reg <= 16'h0000;
      pair_reg <= 8'h00;
      half_reg <= 1'b0;
      last_reg <= 1'b0;
      cnt_reg <= 4'h0;
      steps_reg <= 5'h00;
      asm_reg <= 8'h00;
      acnt_reg <= 3'h0;
      nb_reg <= '0;
    end else begin
      rs_reg <= rs_next;
      pm_reg <= pm_next;
      sv_reg <= sv_next;
      sym_reg <= sym_next;
      pair_reg <= pair_next;
      half_reg <= half_next;
      last_reg <= last_next;
      cnt_reg <= cnt_next;
      steps_reg <= steps_next;
      asm_reg <= asm_next;
      acnt_reg <= acnt_next;
      nb_reg <= nb_next;
    end
  end

  fec_pair_buf #(.WIDTH(9)) u_rx_buf (
    .clk(MCLK),
    .rst(RST),
    .in_valid(rxb_push),
    .in_ready(rxb_ready),
    .in_data({rxb_last, rxb_data}),
    .out_valid(RX_OUT_VALID),
    .out_ready(RX_OUT_READY),
    .out_data({RX_OUT_LAST, RX_OUT_DATA})
  );

  sequence s_tx_take;
    TX_IN_VALID && TX_IN_READY;
  endsequence
  sequence s_rx_pair;
    rs_reg == fec_pkg::RX_COLLECT && coded && RX_IN_VALID && half_reg;
  endsequence

  AST_TX_UNCODED: assert property (@(posedge MCLK) disable iff (RST) // see R01
    s_tx_take ##0 !CODING_ENABLE |=> pcnt_reg == 2'h1
      && pend_reg[15:8] == $past(TX_IN_DATA))
    else $error("uncoded byte not passed through");
  AST_TX_LEN_MODE: assert property (@(posedge MCLK) // see R02
    disable iff (RST)
    s_tx_take ##0 (LENGTH_MODE != `FEC_LEN_FIXED) |=> pcnt_reg == 2'h1)
    else $error("coding used outside fixed length mode");
  AST_TX_RATE_HALF: assert property (@(posedge MCLK) // see R04
    disable iff (RST)
    s_tx_take ##0 coded |=> pcnt_reg == 2'h2 ##1 tx_push)
    else $error("coded byte did not yield two bytes");
  AST_TX_MATRIX: assert property (@(posedge MCLK) disable iff (RST) // see R07
    s_tx_take ##0 (coded && TX_IN_DATA == 8'h80 && enc_reg == 3'h0)
      |=> pend_reg == 16'h8CCC)
    else $error("interleaved pattern wrong");
  AST_TX_PAD: assert property (@(posedge MCLK) disable iff (RST) // see R11
    s_tx_take ##0 (coded && TX_IN_LAST) |=>
      pad_reg == ($past(par_reg) ? `FEC_PAD_EVEN : `FEC_PAD_ODD))
    else $error("pad count wrong");
  AST_TX_PAD_HOLD: assert property (@(posedge MCLK) // see R10
    disable iff (RST)
    pad_reg != 2'h0 |-> !TX_IN_READY)
    else $error("input taken during termination");
  AST_TX_ENC_CLEAR: assert property (@(posedge MCLK) // see R14
    disable iff (RST)
    pad_reg == 2'h1 && pcnt_reg == 2'h0 |=> enc_reg == 3'h0 && end_reg)
    else $error("encoder not cleared at packet end");
  AST_RX_DECODE: assert property (@(posedge MCLK) disable iff (RST) // see R08
    s_rx_pair |=> rs_reg == fec_pkg::RX_DECODE
      && sym_reg == transpose({$past(pair_reg), $past(RX_IN_DATA)}))
    else $error("pair not de-interleaved into decoder");
  AST_RX_DROP: assert property (@(posedge MCLK) disable iff (RST) // see R12
    rxb_push && rs_reg != fec_pkg::RX_COLLECT |-> nb_reg < PACKET_LENGTH)
    else $error("pad byte reached receive output");
  AST_RX_CLEAN: assert property (@(posedge MCLK) disable iff (RST) // see R09
    rs_reg == fec_pkg::RX_FLUSH && cnt_reg == `FEC_FLUSH_LAST && rxb_ready
      |=> pm_reg[0] == 8'h00 && steps_reg == 5'h00)
    else $error("decoder not restarted after packet");
endmodule
`default_nettype wire

// ---- fec_defines.svh ----
/*
  Constants of the error-correcting codec: code generators, interleaver
  geometry, decoder metric settings and the packet length mode code.
  Assumes inclusion by bare name from the codec module and the testbench.
*/
// Summary of operation
// R01: Coding runs only while the coding enable input is one; else bytes pass.
// R02: Coding is used only in fixed packet length mode, code zero.
// R03: Only data field and CRC pass here; preamble and sync never do.
// R04: Rate one half, constraint length four: two coded bits per data bit.
// R05: Enabled coding always brings interleaving and de-interleaving along.
// R06: Interleaver and de-interleaver are each a four by four bit matrix.
// R07: Transmit writes coded bits by rows and sends them by columns.
// R08: Receive writes symbols by rows and decodes them by columns.
// R09: The decoder recovers payload bits despite a few bit errors.
// R10: Coded transmit appends at least one trellis termination byte.
// R11: One or two pad bytes make the coded byte count even.
// R12: Receive drops termination and pad bytes before the receive FIFO.
// R13: The packet source uses payloads of at least two bytes when coding.
// R14: Encoder clears at each packet start; generators are fixed constants.
`ifndef FEC_DEFINES_SVH
`define FEC_DEFINES_SVH
`define FEC_G0 4'b1101
`define FEC_G1 4'b1111
`define FEC_LEN_FIXED 2'b00
`define FEC_METRIC_INIT 8'h20
`define FEC_GROUP_LAST 4'h7
`define FEC_FLUSH_LAST 4'hE
`define FEC_DELAY_MIN 5'h0F
`define FEC_STEPS_SAT 5'h10
`define FEC_PAD_ODD 2'h1
`define FEC_PAD_EVEN 2'h2
`endif

// ---- fec_pkg.sv ----
/*
  Types shared by the codec: receive sequencer states and decoder words.
  Assumes nothing beyond the constants header.
*/
`default_nettype none
package fec_pkg;
  typedef enum logic [1:0] {
    RX_COLLECT = 2'b00,
    RX_DECODE = 2'b01,
    RX_FLUSH = 2'b10
  } rx_state_e;
  typedef logic [7:0] metric_t;
  typedef logic [15:0] surv_t;
endpackage
`default_nettype wire

// ---- fec_modem_model.sv ----
/*
  Modem model: loops transmitted over-air bytes back as received bytes.
  It can stall both sides and can flip bits of the third byte of a packet.
  Assumes a single clock shared with the codec.
*/
`timescale 1ns/100ps
`default_nettype none
module fec_modem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [7:0] flip,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_last
);
  logic [8:0] fifo[$];
  int idx = 0;
  logic took = 1'b0;
  always @(posedge clk) begin
    took = rx_valid && rx_ready;
    if (rst) begin
      fifo.delete();
      idx = 0;
    end
    if (tx_valid && tx_ready) begin
      fifo.push_back({tx_last, tx_data});
    end
    if (took) begin
      void'(fifo.pop_front());
      idx = rx_last ? 0 : idx + 1;
    end
  end
  // A released data line shows the inverse of its last value
  always @(negedge clk) begin
    tx_ready <= !rst && !slow && fifo.size() < 4;
    if (rst || took) begin
      rx_valid <= 1'b0;
      rx_data <= rst ? 8'h00 : ~rx_data;
      rx_last <= 1'b0;
    end else if (!rx_valid && fifo.size() > 0 && !slow) begin
      rx_valid <= 1'b1;
      rx_data <= fifo[0][7:0] ^ ((idx == 2) ? flip : 8'h00);
      rx_last <= fifo[0][8];
    end
  end
endmodule
`default_nettype wire

// ---- test_fec_interleave_codec.sv ----
/*
  Self-checking bench: random packets in coded and plain modes pass the
  encoder, the modem model and the decoder; both streams are compared.
  Assumes the codec, its constants header and the modem model.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fec_defines.svh"
module test_fec_interleave_codec;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic CODING_ENABLE = 1'b1;
  logic [1:0] LENGTH_MODE = 2'b00;
  logic [7:0] PACKET_LENGTH = 8'h02;
  logic TX_IN_VALID = 1'b0;
  logic [7:0] TX_IN_DATA = 8'h00;
  logic TX_IN_LAST = 1'b0;
  logic RX_OUT_READY = 1'b0;
  logic TX_IN_READY, TX_OUT_VALID, TX_OUT_READY, TX_OUT_LAST;
  logic RX_IN_VALID, RX_IN_READY, RX_IN_LAST, RX_OUT_VALID, RX_OUT_LAST;
  logic [7:0] TX_OUT_DATA, RX_IN_DATA, RX_OUT_DATA;
  logic slow = 1'b0;
  logic [7:0] flip = 8'h00;
  int cyc = 0;
  int hold_end = 0;
  logic tx_took = 1'b0, tx_hit = 1'b0, rx_hit = 1'b0;
  logic [8:0] tx_seen, rx_seen;
  logic [8:0] tx_want, rx_want;
  logic [8:0] tx_exp[$];
  logic [8:0] rx_exp[$];
  int failures = 0;
  int tests_run = 0;

  always #5 MCLK = ~MCLK;

  fec_interleave_codec fec_interleave_codec_inst (
    .MCLK(MCLK), .RST(RST), .CODING_ENABLE(CODING_ENABLE),
    .LENGTH_MODE(LENGTH_MODE), .PACKET_LENGTH(PACKET_LENGTH),
    .TX_IN_VALID(TX_IN_VALID), .TX_IN_READY(TX_IN_READY),
    .TX_IN_DATA(TX_IN_DATA), .TX_IN_LAST(TX_IN_LAST),
    .TX_OUT_VALID(TX_OUT_VALID), .TX_OUT_READY(TX_OUT_READY),
    .TX_OUT_DATA(TX_OUT_DATA), .TX_OUT_LAST(TX_OUT_LAST),
    .RX_IN_VALID(RX_IN_VALID), .RX_IN_READY(RX_IN_READY),
    .RX_IN_DATA(RX_IN_DATA), .RX_IN_LAST(RX_IN_LAST),
    .RX_OUT_VALID(RX_OUT_VALID), .RX_OUT_READY(RX_OUT_READY),
    .RX_OUT_DATA(RX_OUT_DATA), .RX_OUT_LAST(RX_OUT_LAST)
  );

  fec_modem_model fec_modem_model_inst (
    .clk(MCLK), .rst(RST), .slow(slow), .flip(flip),
    .tx_valid(TX_OUT_VALID), .tx_ready(TX_OUT_READY),
    .tx_data(TX_OUT_DATA), .tx_last(TX_OUT_LAST),
    .rx_valid(RX_IN_VALID), .rx_ready(RX_IN_READY),
    .rx_data(RX_IN_DATA), .rx_last(RX_IN_LAST)
  );

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Encodes one byte, transposes the 4x4 block, notes both air bytes
  task automatic push_coded(input logic [7:0] b, input logic fin,
                            inout logic [2:0] st);
    logic [3:0] w;
    logic [15:0] c;
    logic [15:0] t;
    for (int i = 7; i >= 0; i--) begin
      w = {b[i], st};
      c = {c[13:0], ^(w & `FEC_G0), ^(w & `FEC_G1)};
      st = w[3:1];
    end
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 4; k++) begin
        t[15 - 4 * k - r] = c[15 - 4 * r - k];
      end
    end
    tx_exp.push_back({1'b0, t[15:8]});
    tx_exp.push_back({fin, t[7:0]});
  endtask

  task automatic send_pkt(input int n, input logic coded);
    logic [7:0] pay[16];
    logic [2:0] st;
    int pads;
    int w;
    st = 3'h0;
    pads = (n % 2 == 1) ? 1 : 2;
    PACKET_LENGTH = n[7:0];
    for (int i = 0; i < n; i++) begin
      pay[i] = 8'($urandom);
      if (i == 0 && n == 2) begin
        pay[i] = 8'h80;
      end
      rx_exp.push_back({i == n - 1, pay[i]});
      if (coded) begin
        push_coded(pay[i], 1'b0, st);
      end else begin
        tx_exp.push_back({i == n - 1, pay[i]});
      end
    end
    for (int i = 0; coded && i < pads; i++) begin
      push_coded(8'h00, i == pads - 1, st);
    end
    for (int i = 0; i < n; i++) begin
      TX_IN_VALID = 1'b1;
      TX_IN_DATA = pay[i];
      TX_IN_LAST = (i == n - 1);
      w = 0;
      do begin
        @(negedge MCLK);
        w++;
      end while (!tx_took && w < 300);
      check({8'h00, tx_took}, 9'h001);
    end
    TX_IN_VALID = 1'b0;
    TX_IN_LAST = 1'b0;
    w = 0;
    while ((tx_exp.size() > 0 || rx_exp.size() > 0) && w < 3000) begin
      @(negedge MCLK);
      w++;
    end
    check({8'h00, tx_exp.size() + rx_exp.size() == 0}, 9'h001);
  endtask

  always @(posedge MCLK) begin
    tx_took <= TX_IN_VALID && TX_IN_READY;
    tx_hit <= TX_OUT_VALID && TX_OUT_READY;
    rx_hit <= RX_OUT_VALID && RX_OUT_READY;
    tx_seen <= {TX_OUT_LAST, TX_OUT_DATA};
    rx_seen <= {RX_OUT_LAST, RX_OUT_DATA};
  end

  // Oldest note is taken off each queue whenever a byte leaves
  always @(negedge MCLK) begin
    if (tx_hit) begin
      tx_want = tx_exp.size() > 0 ? tx_exp.pop_front() : 9'hxxx;
      check(tx_seen, tx_want);
    end
    if (rx_hit) begin
      rx_want = rx_exp.size() > 0 ? rx_exp.pop_front() : 9'hxxx;
      check(rx_seen, rx_want);
    end
  end

  // Random stalls on both far sides; a long hold fills the output buffer
  always @(negedge MCLK) begin
    RX_OUT_READY <= cyc >= hold_end && ($urandom % 4 != 0);
    slow <= ($urandom % 4 == 0);
    cyc <= cyc + 1;
  end

  initial begin
    void'($urandom(32'he5be_fd68));
    repeat (10) @(negedge MCLK);
    RST = 1'b0;
    for (int k = 0; k < 14; k++) begin
      CODING_ENABLE = (k != 10);
      LENGTH_MODE = (k > 10) ? 2'(k - 10) : 2'b00;
      flip = (k == 4) ? 8'h10 : ((k == 7) ? 8'h0C : 8'h00);
      if (k == 5) begin
        hold_end = cyc + 150;
      end
      send_pkt((k < 10) ? 2 + k % 6 : 3, k < 10);
      repeat (16) @(negedge MCLK);
    end
    finish_test();
  end

  // Whole run needs well under a tenth of this span
  initial begin
    #400_000;
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
